// ---- verilog/teep_defines.svh ----
// constants for the two-wire serial memory target: timing, field positions, reset values
// assumes a 20 MHz system clock; included by bare name
`ifndef TEEP_DEFINES_SVH
`define TEEP_DEFINES_SVH

`define TEEP_CLK_PERIOD_NS 50
`define TEEP_CLK_RATE_KHZ 20000

// longest pulse that the input filter must reject; rounded up to whole cycles
`define TEEP_GLITCH_REJECT_TIME_NS 50
`define TEEP_GLITCH_CYCLES ((`TEEP_GLITCH_REJECT_TIME_NS + `TEEP_CLK_PERIOD_NS - 1) / `TEEP_CLK_PERIOD_NS)

// self-timed program cycle, longest time, an exact whole number of cycles
`define TEEP_PROGRAM_CYCLE_TIME_MS 5
`define TEEP_PROGRAM_CYCLES (`TEEP_PROGRAM_CYCLE_TIME_MS * `TEEP_CLK_RATE_KHZ)

// far side keeps the bus clock at or below this
`define TEEP_BUS_CLOCK_RATE_LIMIT_KHZ 1000

// device address byte layout
`define TEEP_DEV_PREFIX 4'ha
`define TEEP_DEV_PREFIX_MSB 7
`define TEEP_DEV_PREFIX_LSB 4
`define TEEP_DEV_CS_MSB 3
`define TEEP_DEV_CS_LSB 1
`define TEEP_DEV_RW_POS 0

// byte and page geometry
`define TEEP_BYTE_BITS 4'h8
`define TEEP_LAST_TX_BIT 4'h7
`define TEEP_PAGE_BYTES 17'h00008
`define TEEP_PAGE_LSB_W 3

// reset values
`define TEEP_BUS_IDLE 2'h3
`define TEEP_PIN_IDLE 4'h0

`endif

// ---- verilog/teep_pkg.sv ----
// types shared by the two-wire serial memory target
// assumes nothing beyond a SystemVerilog compiler
package teep_pkg;

  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_rx = 3'b001,
    st_ack = 3'b010,
    st_tx = 3'b011,
    st_mack = 3'b100,
    st_prog = 3'b101
  } teep_state_type;

  typedef enum logic [1:0] {
    k_dev = 2'b00,
    k_word = 2'b01,
    k_data = 2'b10
  } teep_kind_type;

  typedef struct packed {
    logic scl;
    logic sda;
  } teep_bus_type;

  typedef struct packed {
    logic [2:0] cs;
    logic guard;
  } teep_pins_type;

  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } teep_wr_type;

  typedef struct packed {
    teep_state_type state;
    teep_kind_type kind;
    logic rw;
    logic [3:0] bitcnt;
    logic [7:0] shift;
    logic [7:0] addr;
    logic [7:0][7:0] pagebuf;
    logic [7:0] mask;
    logic mack;
    logic [16:0] pcnt;
    logic sda_oe;
    logic sda_o;
    logic busy;
    logic scl_d;
    logic sda_d;
  } teep_main_type;

endpackage

// ---- verilog/teep_filter.sv ----
// two-flop synchroniser followed by a glitch filter, one lane per input bit
// assumes raw inputs are asynchronous pins; clean output changes only after a stable run
`timescale 1ns/10ps
`include "teep_defines.svh"

module teep_filter #(
  parameter int W = 2,
  parameter logic [W-1:0] IDLE = '0
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [W-1:0] raw,
  output logic [W-1:0] clean
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] clean;
    logic [W-1:0][2:0] cnt;
  } teep_filter_state_type;

  localparam logic [2:0] GLITCH = 3'(`TEEP_GLITCH_CYCLES);

  teep_filter_state_type s_reg;
  teep_filter_state_type s_next;

  always_comb begin
    s_next = s_reg;
    s_next.s1 = raw;
    s_next.s2 = s_reg.s1;
    for (int i = 0; i < W; i++) begin
      // a new level must be seen on one more sample than a rejected pulse can span
      if (s_reg.s2[i] != s_reg.clean[i]) begin
        if (s_reg.cnt[i] == GLITCH) begin
          s_next.clean[i] = s_reg.s2[i];
          s_next.cnt[i] = 3'h0;
        end else begin
          s_next.cnt[i] = s_reg.cnt[i] + 3'h1;
        end
      end else begin
        s_next.cnt[i] = 3'h0;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_reg.s1 <= IDLE;
      s_reg.s2 <= IDLE;
      s_reg.clean <= IDLE;
      s_reg.cnt <= '0;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  assign clean = s_reg.clean;

endmodule // teep_filter

// ---- verilog/teep_array.sv ----
// 256 x 8 storage with one write port and a registered read port
// assumes contents are not cleared by reset, as befits nonvolatile storage
`timescale 1ns/10ps

module teep_array (
  input wire logic clock,
  input wire logic rstn,
  input wire logic clk_en,
  input teep_pkg::teep_wr_type wr,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data
);

  logic [7:0] mem [0:255];
  logic [7:0] rd_data_reg;

  always_ff @(posedge clock) begin
    if (clk_en && wr.en) begin
      mem[wr.addr] <= wr.data;
    end
  end

  // read lags the address by one cycle; the bus bit time hides it
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rd_data_reg <= 8'h00;
    end else if (clk_en) begin
      rd_data_reg <= mem[rd_addr];
    end
  end

  assign rd_data = rd_data_reg;

endmodule // teep_array

// ---- verilog/teep_target.sv ----
// target-side logic of a 256-byte two-wire serial nonvolatile memory
// assumes scl, sda and the straps are asynchronous pins; sda wire is resolved outside
`timescale 1ns/10ps
`include "teep_defines.svh"

module teep_target #(
  parameter int PROG_CYCLES = `TEEP_PROGRAM_CYCLES
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic [2:0] chip_select_inputs,
  input wire logic write_guard,
  output logic sda_out,
  output logic sda_oe,
  output logic program_busy
);

  localparam logic [16:0] PROG_LAST = 17'(PROG_CYCLES - 1);

  teep_pkg::teep_main_type s_reg;
  teep_pkg::teep_main_type s_next;
  teep_pkg::teep_bus_type bus;
  teep_pkg::teep_pins_type pins;
  teep_pkg::teep_wr_type wr;
  logic [7:0] rd_data;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [2:0] idx;
  logic sda_rise;
  logic sda_fall;
  logic byte_done;
  logic tx_last;
  logic is_read;
  logic commit_ok;
  logic prog_write;
  logic prog_done;
  logic [7:0] lane_sel;
  logic [7:0] rd_addr;

  function automatic logic dev_match(input logic [7:0] b, input logic [2:0] cs);
    logic prefix_ok;
    logic select_ok;
    prefix_ok = (b[`TEEP_DEV_PREFIX_MSB:`TEEP_DEV_PREFIX_LSB] == `TEEP_DEV_PREFIX);
    select_ok = (b[`TEEP_DEV_CS_MSB:`TEEP_DEV_CS_LSB] == cs);
    dev_match = prefix_ok && select_ok;
  endfunction

  // open drain: a zero is pulled low, a one is left to the pull-up
  function automatic logic pull_for(input logic b);
    pull_for = ~b;
  endfunction

  // a write moves from the word address on to data bytes
  function automatic teep_pkg::teep_kind_type kind_after(input teep_pkg::teep_kind_type k);
    if (k == teep_pkg::k_dev) begin
      kind_after = teep_pkg::k_word;
    end else begin
      kind_after = teep_pkg::k_data;
    end
  endfunction

  // both directions move msb first through the same register
  function automatic logic [7:0] shift_in(input logic [7:0] s, input logic b);
    shift_in = {s[6:0], b};
  endfunction

  teep_filter #(
    .W(2),
    .IDLE(`TEEP_BUS_IDLE)
  ) u_bus_filter (
    .clock(clock),
    .rstn(rstn),
    .clk_en(clk_en),
    .raw({scl_in, sda_in}),
    .clean(bus)
  );

  // straps pass the same filter; a slow strap change costs nothing
  teep_filter #(
    .W(4),
    .IDLE(`TEEP_PIN_IDLE)
  ) u_pin_filter (
    .clock(clock),
    .rstn(rstn),
    .clk_en(clk_en),
    .raw({chip_select_inputs, write_guard}),
    .clean(pins)
  );

  teep_array u_array (
    .clock(clock),
    .rstn(rstn),
    .clk_en(clk_en),
    .wr(wr),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  assign scl_rise = bus.scl & ~s_reg.scl_d;
  assign scl_fall = ~bus.scl & s_reg.scl_d;
  assign sda_rise = bus.sda & ~s_reg.sda_d;
  assign sda_fall = ~bus.sda & s_reg.sda_d;
  // start and stop are sda edges while the bus clock stays high
  assign start_seen = bus.scl & s_reg.scl_d & sda_fall;
  assign stop_seen = bus.scl & s_reg.scl_d & sda_rise;
  assign idx = s_reg.pcnt[2:0];
  assign byte_done = scl_fall && (s_reg.bitcnt == `TEEP_BYTE_BITS);
  assign tx_last = (s_reg.bitcnt == `TEEP_LAST_TX_BIT);
  assign is_read = (s_reg.kind == teep_pkg::k_dev) && s_reg.rw;
  // guard is looked at only once, when the stop arrives
  assign commit_ok = |s_reg.mask && !pins.guard;
  assign prog_write = (s_reg.pcnt < `TEEP_PAGE_BYTES);
  assign prog_done = (s_reg.pcnt == PROG_LAST);
  // read port follows the address counter continuously
  assign rd_addr = s_reg.addr;

  // one lane per page byte, shared by the buffer and the mask
  for (genvar g = 0; g < 8; g++) begin : g_lane
    assign lane_sel[g] = (s_reg.addr[2:0] == 3'(g));
  end

  always_comb begin
    s_next = s_reg;
    wr = '0;
    s_next.scl_d = bus.scl;
    s_next.sda_d = bus.sda;
    s_next.sda_o = 1'b0;
    if (s_reg.state == teep_pkg::st_prog) begin
      // bus activity is not looked at here, so polling gets no ack
      // one array byte per cycle while the counter is below a page
      if (prog_write) begin
        wr.en = s_reg.mask[idx];
        wr.addr = {s_reg.addr[7:`TEEP_PAGE_LSB_W], idx};
        wr.data = s_reg.pagebuf[idx];
      end
      if (prog_done) begin
        s_next.state = teep_pkg::st_idle;
        s_next.pcnt = 17'h00000;
        s_next.mask = 8'h00;
      end else begin
        s_next.pcnt = s_reg.pcnt + 17'h00001;
      end
    // a start restarts the byte engine and drops unsent page data
    end else if (start_seen) begin
      s_next.state = teep_pkg::st_rx;
      s_next.kind = teep_pkg::k_dev;
      s_next.bitcnt = 4'h0;
      s_next.sda_oe = 1'b0;
      s_next.mask = 8'h00;
    end else if (stop_seen) begin
      s_next.sda_oe = 1'b0;
      s_next.pcnt = 17'h00000;
      if (commit_ok) begin
        s_next.state = teep_pkg::st_prog;
      end else begin
        s_next.state = teep_pkg::st_idle;
        s_next.mask = 8'h00;
      end
    end else begin
      // byte engine, moved only by filtered bus clock edges
      case (s_reg.state)
        teep_pkg::st_rx: begin
          if (scl_rise) begin
            s_next.shift = shift_in(s_reg.shift, bus.sda);
            s_next.bitcnt = s_reg.bitcnt + 4'h1;
          end else if (byte_done) begin
            s_next.bitcnt = 4'h0;
            s_next.sda_oe = 1'b1;
            s_next.state = teep_pkg::st_ack;
            case (s_reg.kind)
              teep_pkg::k_dev: begin
                if (dev_match(s_reg.shift, pins.cs)) begin
                  s_next.rw = s_reg.shift[`TEEP_DEV_RW_POS];
                end else begin
                  s_next.sda_oe = 1'b0;
                  s_next.state = teep_pkg::st_idle;
                end
              end
              teep_pkg::k_word: begin
                s_next.addr = s_reg.shift;
              end
              default: begin
                // the loop keeps one fixed write per lane, no variable index
                for (int j = 0; j < 8; j++) begin
                  if (lane_sel[j]) begin
                    s_next.pagebuf[j] = s_reg.shift;
                    s_next.mask[j] = 1'b1;
                  end
                end
                s_next.addr = {s_reg.addr[7:3], s_reg.addr[2:0] + 3'h1};
              end
            endcase
          end
        end

        teep_pkg::st_ack: begin
          if (scl_fall) begin
            s_next.bitcnt = 4'h0;
            if (is_read) begin
              s_next.state = teep_pkg::st_tx;
              s_next.shift = rd_data;
              s_next.sda_oe = pull_for(rd_data[7]);
            end else begin
              s_next.sda_oe = 1'b0;
              s_next.state = teep_pkg::st_rx;
              s_next.kind = kind_after(s_reg.kind);
            end
          end
        end

        teep_pkg::st_tx: begin
          if (scl_fall) begin
            s_next.bitcnt = s_reg.bitcnt + 4'h1;
            if (tx_last) begin
              s_next.sda_oe = 1'b0;
              s_next.state = teep_pkg::st_mack;
              s_next.mack = 1'b0;
              // reads roll over the whole array, unlike page writes
              s_next.addr = s_reg.addr + 8'h01;
            end else begin
              s_next.shift = shift_in(s_reg.shift, 1'b0);
              s_next.sda_oe = pull_for(s_reg.shift[6]);
            end
          end
        end

        teep_pkg::st_mack: begin
          if (scl_rise) begin
            s_next.mack = ~bus.sda;
          end else if (scl_fall) begin
            s_next.bitcnt = 4'h0;
            if (s_reg.mack) begin
              s_next.state = teep_pkg::st_tx;
              s_next.shift = rd_data;
              s_next.sda_oe = pull_for(rd_data[7]);
            end else begin
              s_next.state = teep_pkg::st_idle;
            end
          end
        end
        default: begin
          s_next.sda_oe = 1'b0;
        end
      endcase
    end

    // busy is registered so the pin comes straight from a flip-flop
    s_next.busy = (s_next.state == teep_pkg::st_prog);
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_reg.state <= teep_pkg::st_idle;
      s_reg.kind <= teep_pkg::k_dev;
      s_reg.rw <= 1'b0;
      s_reg.bitcnt <= 4'h0;
      s_reg.shift <= 8'h00;
      s_reg.addr <= 8'h00;
      s_reg.pagebuf <= '0;
      s_reg.mask <= 8'h00;
      s_reg.mack <= 1'b0;
      s_reg.pcnt <= 17'h00000;
      s_reg.sda_oe <= 1'b0;
      s_reg.sda_o <= 1'b0;
      s_reg.busy <= 1'b0;
      // filtered bus idles high, so the edge history starts high too
      s_reg.scl_d <= 1'b1;
      s_reg.sda_d <= 1'b1;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  assign sda_out = s_reg.sda_o;
  assign sda_oe = s_reg.sda_oe;
  assign program_busy = s_reg.busy;

endmodule // teep_target

// ---- tb/teep_target_monitor.sv ----
// pin checker for the two-wire memory target
// assumes clk_en is held high; bound to every target instance
`timescale 1ns/10ps

module teep_target_monitor #(
  parameter int PROG_CYCLES = 64
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic write_guard,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic program_busy
);
  logic [16:0] busy_cnt;

  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) busy_cnt <= '0;
    else if (program_busy) busy_cnt <= busy_cnt + 17'h1;
    else busy_cnt <= '0;
  end

  a_open_drain: assert property (sda_out == 1'b0)
    else $error("sda driven high");
  a_busy_no_ack: assert property (program_busy |-> !sda_oe)
    else $error("answer while programming");
  a_prog_bound: assert property (busy_cnt <= PROG_CYCLES)
    else $error("program cycle too long");
  a_prog_full: assert property ($fell(program_busy) |-> busy_cnt >= PROG_CYCLES - 1)
    else $error("program cycle cut short");
  a_guard_skip: assert property ($rose(program_busy) |-> !write_guard && !$past(write_guard, 8))
    else $error("program cycle under guard");
  a_after_stop: assert property ($rose(program_busy) |-> scl_in && sda_in && $past(sda_in, 3))
    else $error("program cycle without stop");
  a_edge_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda changed with bus clock high");
  a_hold_high: assert property (sda_oe && scl_in |=> sda_oe)
    else $error("sda released with bus clock high");
endmodule // teep_target_monitor

bind teep_target teep_target_monitor #(.PROG_CYCLES(PROG_CYCLES)) teep_target_monitor_i (
  .clock, .rstn, .scl_in, .sda_in, .write_guard, .sda_out, .sda_oe, .program_busy);

// ---- tb/teep_host.sv ----
// bus controller model driving scl and pulling sda low
// assumes an external pull-up and one caller at a time
`timescale 1ns/10ps

module teep_host (
  input wire logic clock,
  input wire logic sda,
  output logic scl,
  output logic pull
);
  logic glitch = 1'b0;

  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  // 1 us bit cell keeps the rate limit; long low phase leaves room for a late answer
  task automatic bitx(input logic b, output logic r);
    cyc(1);
    if (glitch) begin // one-cycle spike while low
      scl = 1'b1;
      cyc(1);
      scl = 1'b0;
    end
    cyc(8);
    pull = !b; // data moves only with the clock low
    cyc(3);
    scl = 1'b1;
    cyc(7);
    r = sda;
    cyc(1);
    scl = 1'b0;
  endtask

  task automatic start();
    cyc(9);
    pull = 1'b0;
    cyc(3);
    scl = 1'b1;
    cyc(8);
    pull = 1'b1;
    cyc(8);
    scl = 1'b0;
  endtask

  task automatic stop();
    cyc(9);
    pull = 1'b1;
    cyc(3);
    scl = 1'b1;
    cyc(8);
    pull = 1'b0;
    cyc(12);
  endtask

  // msb first, ninth bit is the answer
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) bitx(d[i], q[i]);
  endtask
endmodule // teep_host

// ---- tb/teep_target_tb.sv ----
// self-checking bench for the two-wire memory target
// assumes the controller model and pin checker are compiled alongside
`timescale 1ns/10ps

module teep_target_tb;
  localparam int PC = 400;
  logic clock, rstn, guard, scl, pull, sda_oe, sda_out, busy;
  logic [2:0] cs;
  logic [8:0] q;
  logic [7:0] mem [256];
  int failures, checks_done, cycles;
  wire sda = !(pull || sda_oe);

  teep_target #(.PROG_CYCLES(PC)) teep_target_i (.clock(clock), .rstn(rstn), .clk_en(1'b1),
    .scl_in(scl), .sda_in(sda), .chip_select_inputs(cs), .write_guard(guard),
    .sda_out(sda_out), .sda_oe(sda_oe), .program_busy(busy));
  teep_host teep_host_i (.clock(clock), .sda(sda), .scl(scl), .pull(pull));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (failures == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tx(input logic [7:0] d, input logic ack);
    teep_host_i.xfer({d, 1'b1}, q);
    cmp(q[0], !ack);
  endtask

  task automatic wr(input logic [7:0] a, input int n, input logic [7:0] d0);
    teep_host_i.start();
    tx({4'ha, cs, 1'b0}, 1'b1);
    tx(a, 1'b1);
    for (int i = 0; i < n; i++) begin
      tx(d0 + 8'(i), 1'b1);
      if (!guard) mem[{a[7:3], a[2:0] + 3'(i)}] = d0 + 8'(i);
    end
    teep_host_i.stop();
  endtask

  task automatic rdseq(input logic [7:0] a, input int n);
    teep_host_i.start();
    tx({4'ha, cs, 1'b0}, 1'b1);
    tx(a, 1'b1);
    teep_host_i.start();
    tx({4'ha, cs, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++) begin
      teep_host_i.xfer({8'hff, i == n - 1}, q);
      cmp(q[8:1], mem[a + 8'(i)]);
    end
    teep_host_i.stop();
  endtask

  // poll once during the program cycle, then wait without bus clocks
  task automatic settle(input logic exp_busy);
    cmp(busy, exp_busy);
    teep_host_i.start();
    tx({4'ha, cs, 1'b0}, !exp_busy);
    teep_host_i.stop();
    repeat (PC) if (busy === 1'b1) @(negedge clock);
    cmp(busy, 1'b0);
  endtask

  task automatic t_select();
    for (int k = 0; k < 8; k++) begin
      cs = 3'(k);
      repeat (10) @(negedge clock);
      teep_host_i.start();
      tx({4'ha, cs ^ 3'h1, 1'b0}, 1'b0);
      teep_host_i.start();
      tx({4'hb, cs, 1'b0}, 1'b0);
      teep_host_i.start();
      tx({4'ha, cs, 1'b0}, 1'b1); // k of 0 is the five-lead case
      teep_host_i.stop();
    end
  endtask

  task automatic t_page();
    wr(8'h3e, 10, 8'h20);
    settle(1'b1);
    rdseq(8'h38, 8);
  endtask

  task automatic t_partial();
    wr(8'h00, 8, 8'h10);
    settle(1'b1);
    wr(8'hf8, 8, 8'h40);
    settle(1'b1);
    wr(8'h02, 2, 8'ha0);
    settle(1'b1);
    rdseq(8'hfe, 10); // read address wraps to zero
  endtask

  task automatic t_guard();
    guard = 1'b1;
    wr(8'h03, 3, 8'h55);
    settle(1'b0);
    guard = 1'b0;
    rdseq(8'h00, 8);
  endtask

  task automatic t_glitch();
    teep_host_i.glitch = 1'b1;
    wr(8'h1c, 4, 8'h61);
    teep_host_i.glitch = 1'b0;
    settle(1'b1);
    rdseq(8'h1c, 4);
  endtask

  initial begin
    rstn = 1'b0;
    cs = 3'h0;
    guard = 1'b0;
    repeat (16) @(negedge clock);
    rstn = 1'b1;
    repeat (10) @(negedge clock);
    t_select();
    t_page();
    t_partial();
    t_guard();
    t_glitch();
    give_verdict();
  end
endmodule // teep_target_tb
